//--- rtl/fpsf_pkg.sv
// Constants, encodings and types of the float status and feature registers
package fpsf_pkg;

    // Register width and system-register encoding field widths
    localparam int unsigned FPSF_DW    = 32;
    localparam int unsigned FPSF_OP0_W = 2;
    localparam int unsigned FPSF_OP1_W = 3;
    localparam int unsigned FPSF_CRN_W = 4;
    localparam int unsigned FPSF_CRM_W = 4;
    localparam int unsigned FPSF_OP2_W = 3;
    localparam int unsigned FPSF_EL_W  = 2;

    // Encoding shared by the control and status registers
    localparam logic [1:0] FPSF_CS_OP0 = 2'h3;
    localparam logic [2:0] FPSF_CS_OP1 = 3'h3;
    localparam logic [3:0] FPSF_CS_CRN = 4'h4;
    localparam logic [3:0] FPSF_CS_CRM = 4'h4;
    localparam logic [2:0] FPSF_CTRL_OP2 = 3'h0;
    localparam logic [2:0] FPSF_STAT_OP2 = 3'h1;

    // Encoding shared by the three feature-identification registers
    localparam logic [1:0] FPSF_ID_OP0 = 2'h3;
    localparam logic [2:0] FPSF_ID_OP1 = 3'h0;
    localparam logic [3:0] FPSF_ID_CRN = 4'h0;
    localparam logic [3:0] FPSF_ID_CRM = 4'h3;
    localparam logic [2:0] FPSF_ID0_OP2 = 3'h0;
    localparam logic [2:0] FPSF_ID1_OP2 = 3'h1;
    localparam logic [2:0] FPSF_ID2_OP2 = 3'h2;

    // Least privileged exception level
    localparam logic [1:0] FPSF_EL_USER = 2'h0;

    // Status register layout
    localparam int unsigned FPSF_NZCV_HI = 31;
    localparam int unsigned FPSF_NZCV_LO = 28;
    localparam int unsigned FPSF_NSTICKY = 7;
    // Sticky positions: invalid, div0, overflow, underflow, inexact,
    // input denormal, saturation (index order of the event vector)
    localparam int unsigned FPSF_STICKY_POS [FPSF_NSTICKY] =
        '{0, 1, 2, 3, 4, 7, 27};
    localparam logic [31:0] FPSF_STAT_MASK  = 32'hf800009f;
    localparam logic [31:0] FPSF_STAT_RESET = 32'h00000000;
    localparam logic [31:0] FPSF_CTRL_RESET = 32'h00000000;

    // Feature register 0 fields
    localparam logic [3:0] FPSF_ROUNDING_SUPPORT      = 4'h1;
    localparam logic [3:0] FPSF_SHORT_VECTOR_SUPPORT  = 4'h0;
    localparam logic [3:0] FPSF_SQUARE_ROOT_SUPPORT   = 4'h1;
    localparam logic [3:0] FPSF_DIVIDE_SUPPORT        = 4'h1;
    localparam logic [3:0] FPSF_TRAP_SUPPORT          = 4'h0;
    localparam logic [3:0] FPSF_DOUBLE_PREC_SUPPORT   = 4'h2;
    localparam logic [3:0] FPSF_SINGLE_PREC_SUPPORT   = 4'h2;
    localparam logic [3:0] FPSF_VECTOR_BANK_SUPPORT   = 4'h2;

    // Feature register 1 fields
    localparam logic [3:0] FPSF_FUSED_MAC_SUPPORT     = 4'h1;
    localparam logic [3:0] FPSF_SCALAR_HALF_SUPPORT   = 4'h3;
    localparam logic [3:0] FPSF_VECTOR_HALF_SUPPORT   = 4'h2;
    localparam logic [3:0] FPSF_VECTOR_SINGLE_SUPPORT = 4'h1;
    localparam logic [3:0] FPSF_VECTOR_INT_SUPPORT    = 4'h1;
    localparam logic [3:0] FPSF_VECTOR_LDST_SUPPORT   = 4'h1;
    localparam logic [3:0] FPSF_NAN_PROP_SUPPORT      = 4'h1;
    localparam logic [3:0] FPSF_DENORMAL_SUPPORT      = 4'h1;

    // Feature register 2 fields
    localparam logic [23:0] FPSF_ID2_RESERVED          = 24'h000000;
    localparam logic [3:0]  FPSF_SCALAR_MISC_SUPPORT   = 4'h4;
    localparam logic [3:0]  FPSF_VECTOR_MISC_SUPPORT   = 4'h3;

    // Register selected by a decoded access
    typedef enum logic [2:0] {
        FPSF_SEL_NONE,
        FPSF_SEL_CTRL,
        FPSF_SEL_STAT,
        FPSF_SEL_ID0,
        FPSF_SEL_ID1,
        FPSF_SEL_ID2
    } fpsf_sel_t;

endpackage

//--- rtl/fpsf_regs.sv
// Float control, status and feature-identification system registers
//
// Summary of operation
// (R1) Control decoded at 11/011/0100/0100/000, read-write at every level.
// (R2) Status decoded at 11/011/0100/0100/001, read-write at every level.
// (R3) Status 31:28 take 32-bit-state compares; 64-bit ones set flags.
// (R4) Status bit 27 sticks on vector saturation until software writes zero.
// (R5) Status bit 7 sticks on input-denormal exception until written zero.
// (R6) Status bit 4 sticks on inexact exception until written zero.
// (R7) Status bit 3 sticks on underflow exception until written zero.
// (R8) Status bit 2 sticks on overflow exception until written zero.
// (R9) Status bit 1 sticks on divide-by-zero exception until written zero.
// (R10) Status bit 0 sticks on invalid-operation exception until written zero.
// (R11) Legacy combined view shares storage with control and status fields.
// (R12) Feature 0: rounding 0x1 in 31:28, short vectors 0x0 in 27:24.
// (R13) Feature 0: square root 0x1 in 23:20, divide 0x1 in 19:16.
// (R14) Feature 0: exception trapping 0x0 in 15:12.
// (R15) Feature 0: 0x2 in 11:8, 7:4 and 3:0.
// (R16) Feature 0 read-only at 11/000/0000/0011/000, no access at level 0.
// (R17) Feature 1: 1 in 31:28, 3 in 27:24, 2 in 23:20.
// (R18) Feature 1: 1 in 19:16, 15:12 and 11:8.
// (R19) Feature 1: 1 in 7:4 and 1 in 3:0.
// (R20) Feature 1 read-only at 11/000/0000/0011/001, no access at level 0.
// (R21) Feature 2: 0x4 in 7:4, bits 31:8 read zero.
// (R22) Feature 2: 0x3 in 3:0.
// (R23) Reserved status bits read zero; stickies set on event cycles or by a write of one.
// (R24) Feature registers ignore writes and are fixed constants.
`timescale 1ns/1ps

module fpsf_regs
    import fpsf_pkg::*;
(
    // Clock and reset
    input  wire logic                         CLK,
    input  wire logic                         RST,
    // System-register move request
    input  wire logic                         SYS_REQ,
    input  wire logic                         SYS_WRITE,
    input  wire logic [fpsf_pkg::FPSF_OP0_W-1:0] SYS_OP0,
    input  wire logic [fpsf_pkg::FPSF_OP1_W-1:0] SYS_OP1,
    input  wire logic [fpsf_pkg::FPSF_CRN_W-1:0] SYS_CRN,
    input  wire logic [fpsf_pkg::FPSF_CRM_W-1:0] SYS_CRM,
    input  wire logic [fpsf_pkg::FPSF_OP2_W-1:0] SYS_OP2,
    input  wire logic [fpsf_pkg::FPSF_EL_W-1:0]  SYS_EL,
    input  wire logic [fpsf_pkg::FPSF_DW-1:0]    SYS_WDATA,
    // System-register move answer
    output logic                              SYS_ACK,
    output logic                              SYS_UNDEF,
    output logic [fpsf_pkg::FPSF_DW-1:0]      SYS_RDATA,
    // Legacy combined-view write port
    input  wire logic                         LEGACY_WR,
    input  wire logic [fpsf_pkg::FPSF_DW-1:0] LEGACY_WDATA,
    // Comparison results from the float unit
    input  wire logic                         CMP_VALID,
    input  wire logic                         CMP_STATE32,
    input  wire logic [3:0]                   CMP_NZCV,
    // Exception and saturation events, one-cycle pulses
    input  wire logic [fpsf_pkg::FPSF_NSTICKY-1:0] STICKY_EVENT,
    // Register contents and condition-flag update
    output logic [fpsf_pkg::FPSF_DW-1:0]      FLOAT_CONTROL_REG,
    output logic [fpsf_pkg::FPSF_DW-1:0]      FLOAT_STATUS_REG,
    output logic                              COND_FLAGS_WE,
    output logic [3:0]                        COND_FLAGS
);
    import fpsf_pkg::*;

    // Decode of the five-field encoding into a register select
    function automatic fpsf_sel_t decode_sel(
        input logic [1:0] op0,
        input logic [2:0] op1,
        input logic [3:0] crn,
        input logic [3:0] crm,
        input logic [2:0] op2
    );
        logic cs_grp;
        logic id_grp;
        cs_grp = (op0 == FPSF_CS_OP0) && (op1 == FPSF_CS_OP1) &&
                 (crn == FPSF_CS_CRN) && (crm == FPSF_CS_CRM);
        id_grp = (op0 == FPSF_ID_OP0) && (op1 == FPSF_ID_OP1) &&
                 (crn == FPSF_ID_CRN) && (crm == FPSF_ID_CRM);
        decode_sel = FPSF_SEL_NONE;
        if (cs_grp && op2 == FPSF_CTRL_OP2) begin
            decode_sel = FPSF_SEL_CTRL;
        end else if (cs_grp && op2 == FPSF_STAT_OP2) begin
            decode_sel = FPSF_SEL_STAT;
        end else if (id_grp && op2 == FPSF_ID0_OP2) begin
            decode_sel = FPSF_SEL_ID0;
        end else if (id_grp && op2 == FPSF_ID1_OP2) begin
            decode_sel = FPSF_SEL_ID1;
        end else if (id_grp && op2 == FPSF_ID2_OP2) begin
            decode_sel = FPSF_SEL_ID2;
        end
    endfunction

    // Fixed feature words; wires, so no reset or write can reach them
    logic [31:0] feature_id_zero;
    logic [31:0] feature_id_one;
    logic [31:0] feature_id_two;

    // (R12) rounding, short vectors
    // (R13) square root, divide
    // (R14) no trapping
    // (R15) precision and bank
    assign feature_id_zero = {FPSF_ROUNDING_SUPPORT,
                              FPSF_SHORT_VECTOR_SUPPORT,
                              FPSF_SQUARE_ROOT_SUPPORT,
                              FPSF_DIVIDE_SUPPORT,
                              FPSF_TRAP_SUPPORT,
                              FPSF_DOUBLE_PREC_SUPPORT,
                              FPSF_SINGLE_PREC_SUPPORT,
                              FPSF_VECTOR_BANK_SUPPORT};
    // (R17) mac and half precision
    // (R18) vector single, integer, ldst
    // (R19) nan and denormal
    assign feature_id_one = {FPSF_FUSED_MAC_SUPPORT,
                             FPSF_SCALAR_HALF_SUPPORT,
                             FPSF_VECTOR_HALF_SUPPORT,
                             FPSF_VECTOR_SINGLE_SUPPORT,
                             FPSF_VECTOR_INT_SUPPORT,
                             FPSF_VECTOR_LDST_SUPPORT,
                             FPSF_NAN_PROP_SUPPORT,
                             FPSF_DENORMAL_SUPPORT};
    // (R21) misc and reserved zero
    // (R22) vector misc value
    assign feature_id_two = {FPSF_ID2_RESERVED,
                             FPSF_SCALAR_MISC_SUPPORT,
                             FPSF_VECTOR_MISC_SUPPORT};

    // State
    logic [31:0] ctrl_q;
    logic [31:0] ctrl_d;
    logic [31:0] stat_q;
    logic [31:0] stat_d;
    logic        ack_q;
    logic        undef_q;
    logic [31:0] rdata_q;
    logic        cond_we_q;
    logic [3:0]  cond_q;

    // Access decode
    fpsf_sel_t   sel;
    logic        user_level;
    logic        id_sel;
    logic        access_ok;
    logic        ctrl_wr;
    logic        stat_wr;
    logic [31:0] read_word;

    assign sel = decode_sel(SYS_OP0, SYS_OP1, SYS_CRN, SYS_CRM, SYS_OP2);
    assign user_level = (SYS_EL == FPSF_EL_USER);
    assign id_sel = (sel == FPSF_SEL_ID0) || (sel == FPSF_SEL_ID1) ||
                    (sel == FPSF_SEL_ID2);

    // (R1) control open at all levels
    // (R2) status open at all levels
    // (R16) feature 0 refused at level 0
    // (R20) feature 1 refused at level 0
    // (R24) feature writes refused
    assign access_ok = (sel == FPSF_SEL_CTRL) || (sel == FPSF_SEL_STAT) ||
                       (id_sel && !user_level && !SYS_WRITE);

    assign ctrl_wr = SYS_REQ && SYS_WRITE && (sel == FPSF_SEL_CTRL);
    assign stat_wr = SYS_REQ && SYS_WRITE && (sel == FPSF_SEL_STAT);

    always_comb begin
        read_word = 32'h00000000;
        unique case (sel)
            FPSF_SEL_NONE: read_word = 32'h00000000;
            FPSF_SEL_CTRL: read_word = ctrl_q;
            FPSF_SEL_STAT: read_word = stat_q;
            FPSF_SEL_ID0:  read_word = feature_id_zero;
            FPSF_SEL_ID1:  read_word = feature_id_one;
            FPSF_SEL_ID2:  read_word = feature_id_two;
            default:       read_word = 32'h00000000;
        endcase
    end

    // Control storage: a system write beats a legacy write in one cycle.
    // The legacy view only owns the bits outside the status field set.
    // (R11) shared control storage
    assign ctrl_d = ctrl_wr   ? SYS_WDATA :
                    LEGACY_WR ? ((ctrl_q & FPSF_STAT_MASK) |
                                 (LEGACY_WDATA & ~FPSF_STAT_MASK)) :
                                ctrl_q;

    // Software base value of the status word before hardware updates
    logic [31:0] stat_sw;
    logic [31:0] stat_cmp;
    logic        cmp32;
    logic        cmp64;

    // (R11) shared status storage
    // (R23) reserved bits masked off
    assign stat_sw = stat_wr   ? (SYS_WDATA & FPSF_STAT_MASK) :
                     LEGACY_WR ? (LEGACY_WDATA & FPSF_STAT_MASK) :
                                 stat_q;

    // (R3) compare flag routing
    assign cmp32 = CMP_VALID && CMP_STATE32;
    assign cmp64 = CMP_VALID && !CMP_STATE32;

    // A compare landing with a software write keeps the compare result
    assign stat_cmp = cmp32 ?
        {CMP_NZCV, stat_sw[FPSF_NZCV_LO-1:0]} : stat_sw;

    // Sticky bits: the event of the cycle wins over a write of zero,
    // so no exception reported in the write cycle is lost.
    genvar gi;
    generate
        for (gi = 0; gi < FPSF_NSTICKY; gi++) begin : g_sticky
            localparam int unsigned P = FPSF_STICKY_POS[gi];
            // (R4) (R5) (R6) (R7) (R8) (R9) (R10) sticky set or hold
            // (R23) set on event cycle or by a write of one
            assign stat_d[P] = stat_cmp[P] | STICKY_EVENT[gi];
        end
    endgenerate

    // Non-sticky bits follow the compare and software path
    genvar gb;
    generate
        for (gb = 0; gb < FPSF_DW; gb++) begin : g_plain
            if (gb != 0 && gb != 1 && gb != 2 && gb != 3 && gb != 4 &&
                gb != 7 && gb != 27) begin : g_bit
                // (R23) reserved stay zero
                assign stat_d[gb] = stat_cmp[gb] & FPSF_STAT_MASK[gb];
            end
        end
    endgenerate

    // Register updates
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ctrl_q <= FPSF_CTRL_RESET;
            stat_q <= FPSF_STAT_RESET;
        end else begin
            ctrl_q <= ctrl_d;
            stat_q <= stat_d;
        end
    end

    // Answer: one cycle after the request, for exactly one cycle
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ack_q   <= 1'b0;
            undef_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            ack_q   <= SYS_REQ;
            undef_q <= SYS_REQ && !access_ok;
            rdata_q <= (SYS_REQ && !SYS_WRITE && access_ok) ?
                       read_word : 32'h00000000;
        end
    end

    // (R3) 64-bit compares to condition flags
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            cond_we_q <= 1'b0;
            cond_q    <= 4'h0;
        end else begin
            cond_we_q <= cmp64;
            cond_q    <= cmp64 ? CMP_NZCV : cond_q;
        end
    end

    assign SYS_ACK           = ack_q;
    assign SYS_UNDEF         = undef_q;
    assign SYS_RDATA         = rdata_q;
    assign FLOAT_CONTROL_REG = ctrl_q;
    assign FLOAT_STATUS_REG  = stat_q;
    assign COND_FLAGS_WE     = cond_we_q;
    assign COND_FLAGS        = cond_q;

endmodule

//--- tb/fpsf_assertions.sv
// Port-level assertions for the float status and feature registers
`timescale 1ns/1ps
module fpsf_assertions (
    // Clock and reset
    input wire logic        CLK,
    input wire logic        RST,
    // Register move
    input wire logic        SYS_REQ,
    input wire logic        SYS_WRITE,
    input wire logic [1:0]  SYS_OP0,
    input wire logic [2:0]  SYS_OP1,
    input wire logic [3:0]  SYS_CRN,
    input wire logic [3:0]  SYS_CRM,
    input wire logic [2:0]  SYS_OP2,
    input wire logic [1:0]  SYS_EL,
    input wire logic [31:0] SYS_WDATA,
    input wire logic        SYS_ACK,
    input wire logic        SYS_UNDEF,
    input wire logic [31:0] SYS_RDATA,
    // Legacy view, events and storage
    input wire logic        LEGACY_WR,
    input wire logic [31:0] LEGACY_WDATA,
    input wire logic        CMP_VALID,
    input wire logic        CMP_STATE32,
    input wire logic [3:0]  CMP_NZCV,
    input wire logic [6:0]  STICKY_EVENT,
    input wire logic [31:0] FLOAT_CONTROL_REG,
    input wire logic [31:0] FLOAT_STATUS_REG,
    input wire logic        COND_FLAGS_WE,
    input wire logic [3:0]  COND_FLAGS
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    wire        cs    = {SYS_OP0, SYS_OP1, SYS_CRN, SYS_CRM} == 13'h1b44;
    wire        id    = {SYS_OP0, SYS_OP1, SYS_CRN, SYS_CRM} == 13'h1803;
    wire        rd_id = SYS_REQ && !SYS_WRITE && id && SYS_EL != 2'h0;
    wire        wr_c  = SYS_REQ && SYS_WRITE && cs && SYS_OP2 == 3'h0;
    wire        wr_s  = SYS_REQ && SYS_WRITE && cs && SYS_OP2 == 3'h1;
    wire        rd_s  = SYS_REQ && !SYS_WRITE && cs && SYS_OP2 == 3'h1;
    wire [31:0] ev    = {4'h0, STICKY_EVENT[6], 19'h0, STICKY_EVENT[5],
                         2'h0, STICKY_EVENT[4:0]};
    wire [31:0] stk   = FLOAT_STATUS_REG & 32'h0800009f;

    AST_ACK_ONE: assert property (SYS_ACK == $past(SYS_REQ))
        else $error("answer not one cycle after request");
    AST_ID0: assert property (rd_id && SYS_OP2 == 3'h0
        |=> !SYS_UNDEF && SYS_RDATA == 32'h10110222) else $error("feature 0");
    AST_ID1: assert property (rd_id && SYS_OP2 == 3'h1 |=>
        !SYS_UNDEF && SYS_RDATA == 32'h13211111) else $error("feature 1");
    AST_ID2: assert property (rd_id && SYS_OP2 == 3'h2 |=>
        !SYS_UNDEF && SYS_RDATA == 32'h00000043) else $error("feature 2");
    AST_ID_REFUSE: assert property (SYS_REQ && id &&
        (SYS_WRITE || SYS_EL == 2'h0) |=> SYS_UNDEF && SYS_RDATA == 32'h0)
        else $error("feature access not refused");
    AST_CTRL_WR: assert property (wr_c |=> !SYS_UNDEF &&
        FLOAT_CONTROL_REG == $past(SYS_WDATA)) else $error("control write");
    AST_STAT_RD: assert property (rd_s |=> !SYS_UNDEF &&
        SYS_RDATA == $past(FLOAT_STATUS_REG)) else $error("status read");
    AST_RES_ZERO: assert property (
        (FLOAT_STATUS_REG & 32'h07ffff60) == 0)
        else $error("reserved status bit set");
    AST_STICKY_SET: assert property (
        |STICKY_EVENT && !LEGACY_WR |=>
        (FLOAT_STATUS_REG & $past(ev)) == $past(ev))
        else $error("sticky set");
    AST_STICKY_HOLD: assert property (!wr_s && !LEGACY_WR |=>
        (stk & $past(stk)) == $past(stk)) else $error("sticky lost");
    AST_CMP32: assert property (
        CMP_VALID && CMP_STATE32 && !LEGACY_WR |=>
        FLOAT_STATUS_REG[31:28] == $past(CMP_NZCV)) else $error("cmp32");
    AST_CMP64: assert property (CMP_VALID && !CMP_STATE32 |=>
        COND_FLAGS_WE && COND_FLAGS == $past(CMP_NZCV)) else $error("cmp64");
    AST_LEGACY: assert property (LEGACY_WR && !wr_c |=>
        FLOAT_CONTROL_REG == (($past(FLOAT_CONTROL_REG) & 32'hf800009f) |
        ($past(LEGACY_WDATA) & 32'h07ffff60)))
        else $error("legacy view not in control");
    cover property (wr_s && |STICKY_EVENT);
    cover property (rd_id);
    cover property (LEGACY_WR);
endmodule
bind fpsf_regs fpsf_assertions u_fpsf_assertions (
    .CLK(CLK), .RST(RST), .SYS_REQ(SYS_REQ), .SYS_WRITE(SYS_WRITE),
    .SYS_OP0(SYS_OP0), .SYS_OP1(SYS_OP1), .SYS_CRN(SYS_CRN),
    .SYS_CRM(SYS_CRM), .SYS_OP2(SYS_OP2), .SYS_EL(SYS_EL),
    .SYS_WDATA(SYS_WDATA), .SYS_ACK(SYS_ACK), .SYS_UNDEF(SYS_UNDEF),
    .SYS_RDATA(SYS_RDATA), .LEGACY_WR(LEGACY_WR),
    .LEGACY_WDATA(LEGACY_WDATA), .CMP_VALID(CMP_VALID),
    .CMP_STATE32(CMP_STATE32), .CMP_NZCV(CMP_NZCV),
    .STICKY_EVENT(STICKY_EVENT), .FLOAT_CONTROL_REG(FLOAT_CONTROL_REG),
    .FLOAT_STATUS_REG(FLOAT_STATUS_REG), .COND_FLAGS_WE(COND_FLAGS_WE),
    .COND_FLAGS(COND_FLAGS));

//--- tb/fpsf_exec_model.sv
// Execution-unit stand-in issuing compare results and sticky events
`timescale 1ns/1ps
module fpsf_exec_model (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // Bench commands, held as levels
    input wire logic [6:0]  ev_cmd,
    input wire logic        cmp_cmd,
    input wire logic        cmp32,
    input wire logic [3:0]  nzcv,
    // Reports toward the register block
    output logic [6:0]      ev_o,
    output logic            cmp_valid,
    output logic            cmp_state32,
    output logic [3:0]      cmp_nzcv
);
    logic [7:0] cmd_q;
    wire  [7:0] fresh = {cmp_cmd, ev_cmd} & ~cmd_q;
    // One pulse per command; result lines scramble while no result stands
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {cmd_q, ev_o, cmp_valid, cmp_state32, cmp_nzcv} <= '0;
        end else begin
            cmd_q <= {cmp_cmd, ev_cmd};
            {cmp_valid, ev_o} <= fresh;
            cmp_state32 <= fresh[7] ? cmp32 : ~cmp_state32;
            cmp_nzcv <= fresh[7] ? nzcv : ~cmp_nzcv;
        end
    end
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the float status and feature registers
`timescale 1ns/1ps
module tb_top;
    import fpsf_pkg::*;
    logic        CLK, RST, SYS_REQ, SYS_WRITE, LEGACY_WR, SYS_ACK, SYS_UNDEF;
    logic        CMP_VALID, CMP_STATE32, COND_FLAGS_WE, cmp_cmd, cmp32;
    logic [1:0]  el;
    logic [3:0]  nzcv, CMP_NZCV, COND_FLAGS;
    logic [6:0]  ev_cmd, STICKY_EVENT;
    logic [15:0] enc;
    logic [31:0] wdata, ldata, SYS_RDATA, ctrl_o, stat_o, ctrl_m, stat_m, d;
    logic [31:0] idv [3] = '{32'h10110222, 32'h13211111, 32'h00000043};
    logic [32:0] exp_q [$];
    int          mismatches, compares, seed, t;
    localparam logic [15:0] CS = 16'hda20, ID = 16'hc018;

    fpsf_regs u_fpsf_regs (.CLK(CLK), .RST(RST), .SYS_REQ(SYS_REQ),
        .SYS_WRITE(SYS_WRITE), .SYS_OP0(enc[15:14]), .SYS_OP1(enc[13:11]),
        .SYS_CRN(enc[10:7]), .SYS_CRM(enc[6:3]), .SYS_OP2(enc[2:0]),
        .SYS_EL(el), .SYS_WDATA(wdata), .SYS_ACK(SYS_ACK),
        .SYS_UNDEF(SYS_UNDEF), .SYS_RDATA(SYS_RDATA), .LEGACY_WR(LEGACY_WR),
        .LEGACY_WDATA(ldata), .CMP_VALID(CMP_VALID),
        .CMP_STATE32(CMP_STATE32), .CMP_NZCV(CMP_NZCV),
        .STICKY_EVENT(STICKY_EVENT), .FLOAT_CONTROL_REG(ctrl_o),
        .FLOAT_STATUS_REG(stat_o), .COND_FLAGS_WE(COND_FLAGS_WE),
        .COND_FLAGS(COND_FLAGS));
    fpsf_exec_model u_fpsf_exec_model (.clk(CLK), .rst(RST), .ev_cmd(ev_cmd),
        .cmp_cmd(cmp_cmd), .cmp32(cmp32), .nzcv(nzcv), .ev_o(STICKY_EVENT),
        .cmp_valid(CMP_VALID), .cmp_state32(CMP_STATE32),
        .cmp_nzcv(CMP_NZCV));

    always #25 CLK = ~CLK;

    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [32:0] seen, input logic [32:0] want);
        compares++;
        if (seen !== want) begin
            mismatches++;
            $display("FAIL %0t: saw %h expected %h", $time, seen, want);
        end
    endtask
    task automatic sreq(input logic w, input logic [15:0] e,
                        input logic [1:0] l, input logic [31:0] x,
                        input logic [32:0] want);
        @(posedge CLK);
        exp_q.push_back(want);
        {SYS_REQ, SYS_WRITE, enc, el, wdata} <= {1'b1, w, e, l, x};
    endtask
    task automatic idle;
        @(posedge CLK);
        {SYS_REQ, LEGACY_WR, cmp_cmd, ev_cmd} <= 10'h0;
    endtask
    task automatic fire(input logic [6:0] e, input logic c, s,
                        input logic [3:0] n);
        @(posedge CLK);
        {SYS_REQ, ev_cmd, cmp_cmd, cmp32, nzcv} <= {1'b0, e, c, s, n};
    endtask
    task automatic drain(input string name);
        idle;
        for (t = 0; t < 10 && exp_q.size() > 0; t++) @(negedge CLK);
        if (exp_q.size() > 0) begin
            mismatches++;
            $display("FAIL %0t: answers missing", $time);
            tally_and_finish();
        end
        $display("test %s done", name);
    endtask
    // Reads both views and expects the shadow copies
    task automatic both(input logic [1:0] l);
        sreq(0, CS, l, 0, {1'b0, ctrl_m});
        sreq(0, CS + 1, l, 0, {1'b0, stat_m});
    endtask
    function automatic logic [31:0] evb(input logic [6:0] e);
        return {4'h0, e[6], 19'h0, e[5], 2'h0, e[4:0]};
    endfunction

    // Answer monitor pairs each answer with the oldest note
    always @(negedge CLK)
        if (SYS_ACK === 1'b1) begin
            if (exp_q.size() == 0)
                chk(33'h0, 33'h1);
            else
                chk({SYS_UNDEF, SYS_RDATA}, exp_q.pop_front());
        end

    initial begin
        {CLK, SYS_REQ, SYS_WRITE, LEGACY_WR, cmp_cmd, cmp32} = '0;
        {el, nzcv, ev_cmd, enc, wdata, ldata, ctrl_m, stat_m} = '0;
        {mismatches, compares, RST, seed} = {64'h0, 1'b1, 32'h051f};
        repeat (8) @(posedge CLK);
        RST <= 1'b0;
        for (int l = 0; l < 4; l++) begin
            both(l[1:0]);
            for (int k = 0; k < 3; k++) begin
                sreq(0, ID + k, l, 0, l == 0 ? 33'h1_0000_0000 : idv[k]);
                sreq(1, ID + k, l, $random(seed), 33'h1_0000_0000);
            end
            sreq(0, ID + 3, l, 0, 33'h1_0000_0000);
            sreq(1, CS + 2, l, 0, 33'h1_0000_0000);
        end
        drain("decode");
        for (int i = 0; i < 8; i++) begin
            d = $random(seed);
            ctrl_m = d;
            stat_m = d & 32'hf800009f;
            sreq(1, CS, i, d, 33'h0);
            sreq(1, CS + 1, i, d, 33'h0);
            both(i[1:0]);
        end
        drain("write");
        for (int i = 0; i < 7; i++) begin
            sreq(1, CS + 1, 2'h1, 0, 33'h0);
            fire(7'h1 << i, 0, 0, 0);
            idle;
            idle;
            stat_m = 32'h1 << FPSF_STICKY_POS[i];
            both(2'h0);
            fire(7'h1 << i, 0, 0, 0);
            sreq(1, CS + 1, 2'h3, 0, 33'h0);
            idle;
            idle;
            both(2'h2);
            sreq(1, CS + 1, 2'h1, 0, 33'h0);
            stat_m = 32'h0;
            both(2'h1);
        end
        drain("sticky");
        for (int i = 0; i < 6; i++) begin
            d = $random(seed);
            // Alternate states so both compare routes are always reached
            d[11] = i[0];
            fire(d[6:0], 1'b1, d[11], d[10:7]);
            idle;
            for (t = 0; t < 4 && COND_FLAGS_WE !== 1'b1; t++) @(negedge CLK);
            if (!d[11])
                chk({COND_FLAGS_WE, COND_FLAGS}, {1'b1, d[10:7]});
            if (!d[11] && t == 4)
                tally_and_finish();
            stat_m = stat_m | evb(d[6:0]);
            stat_m[31:28] = d[11] ? d[10:7] : stat_m[31:28];
            both(2'h1);
        end
        drain("compare");
        for (int i = 0; i < 3; i++) begin
            d = $random(seed);
            @(posedge CLK);
            {SYS_REQ, LEGACY_WR, ldata} <= {1'b0, 1'b1, d};
            idle;
            // Control keeps its own bits where the legacy word holds status
            ctrl_m = (ctrl_m & 32'hf800009f) | (d & 32'h07ffff60);
            stat_m = d & 32'hf800009f;
            both(2'h3);
        end
        drain("legacy");
        @(posedge CLK);
        RST <= 1'b1;
        repeat (2) @(posedge CLK);
        RST <= 1'b0;
        {ctrl_m, stat_m} = '0;
        both(2'h0);
        drain("reset");
        tally_and_finish();
    end
endmodule
